// File: dwa_pkg.sv
// Constants, types and register map of the debug wire acknowledge handshake block
// Functional notes
// - During reset the wire is a mode strap; afterwards only the debug wire.
// - Whoever releases the wire high first drives a short high speed-up pulse.
// - Acknowledges never overlap; at most one command awaits its acknowledge.
// - Status-returning commands give no acknowledge; host waits 512 cycles instead.
// - An error sets a status flag and sends a 64-cycle low long acknowledge.
// - Any acknowledge starts at least 32 serial cycles after command end.
// - Command end is the sixteenth serial cycle of the final bit.
// - With acknowledge disabled, a fixed 16-cycle delay replaces the 32-cycle minimum.
// - Access not granted in 512 core cycles is aborted, flags no-response, long acknowledge.
// - First acknowledge after stop or wait entry is long, when debug is enabled.
// - Long low detected runs resync and drops the pending command and acknowledge.
// - Step into wait completes only when core leaves wait; sets wait bit.
// - Step while still in wait sets no-response and illegal-command flags.
package dwa_pkg;

    // Register byte offsets
    localparam logic [3:0] DWA_OFF_CTRL = 4'h0;
    localparam logic [3:0] DWA_OFF_STATUS = 4'h4;
    localparam logic [3:0] DWA_OFF_INFO = 4'h8;

    // Control register fields
    localparam int DWA_CTRL_ACK_EN = 0;
    localparam int DWA_CTRL_DBG_EN = 1;
    localparam logic [1:0] DWA_CTRL_RST = 2'h0;

    // Status register fields, low three are write one to clear
    localparam int DWA_ST_NO_RESPONSE_FLAG = 0;
    localparam int DWA_ST_ILLEGAL_COMMAND_FLAG = 1;
    localparam int DWA_ST_WAIT = 2;
    localparam int DWA_ST_EXC = 3;
    localparam int DWA_ST_PEND = 4;
    localparam int DWA_ST_MODE = 5;

    // Cycle counts on the serial clock
    localparam logic [7:0] DWA_ACK_MIN_CYC = 8'h20;
    localparam logic [7:0] DWA_NOACK_CYC = 8'h10;
    localparam logic [7:0] DWA_ACK_LOW_CYC = 8'h10;
    localparam logic [7:0] DWA_LONG_ACK_CYC = 8'h40;
    localparam logic [7:0] DWA_SYNC_LOW_CYC = 8'h80;
    localparam logic [7:0] DWA_SYNC_GAP_CYC = 8'h10;
    localparam logic [7:0] DWA_SYNC_RESP_CYC = 8'h80;
    // Grant timeout on the core clock
    localparam logic [9:0] DWA_GNT_TMO_CYC = 10'h200;

    typedef enum {
        DWA_IDLE,
        DWA_ACCESS,
        DWA_CORE_WAIT,
        DWA_HOLD,
        DWA_ACK,
        DWA_SYNC_HIGH,
        DWA_SYNC_GAP,
        DWA_SYNC_RESP
    } dwa_state_e;

    // Command decoder to this block
    typedef struct packed {
        logic end_pulse;
        logic access;
        logic with_status;
        logic step;
    } dwa_cmd_s;

    // Core state seen by this block
    typedef struct packed {
        logic gnt;
        logic wait_mode;
        logic stop_mode;
    } dwa_core_s;

    // Requests and events toward core and decoder
    typedef struct packed {
        logic access_req;
        logic access_abort;
        logic cmd_done;
        logic resync;
    } dwa_req_s;

endpackage : dwa_pkg

// File: dwa_low_meter.sv
// Measures low periods on the debug wire and flags resync requests
`timescale 1ns/1ns
module dwa_low_meter (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic enable,
    input wire logic pin_i,
    output logic resync_req,
    output logic high_seen
);
    import dwa_pkg::*;

    logic [7:0] low_cnt_r;
    logic armed_r;

    // Saturating low counter; only counts while the far side owns the wire
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            low_cnt_r <= 8'h00;
        end else if (!enable || pin_i) begin
            low_cnt_r <= 8'h00;
        end else if (low_cnt_r != DWA_SYNC_LOW_CYC) begin
            low_cnt_r <= low_cnt_r + 8'h01;
        end
    end

    // One pulse per long low, then one when the wire comes back high
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            resync_req <= 1'b0;
            high_seen <= 1'b0;
            armed_r <= 1'b0;
        end else begin
            resync_req <= enable && !pin_i && (low_cnt_r == DWA_SYNC_LOW_CYC - 8'h01);
            high_seen <= armed_r && pin_i;
            if (armed_r && pin_i) begin
                armed_r <= 1'b0;
            end else if (enable && !pin_i && low_cnt_r == DWA_SYNC_LOW_CYC - 8'h01) begin
                armed_r <= 1'b1;
            end
        end
    end

endmodule : dwa_low_meter

// File: dwa_wire_drv.sv
// Drives a low pulse of given length followed by one speed-up cycle
`timescale 1ns/1ns
module dwa_wire_drv (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic start,
    input wire logic [7:0] low_len,
    output logic busy,
    output logic pin_o,
    output logic pin_oe_n
);
    import dwa_pkg::*;

    logic [7:0] cnt_r;
    logic low_r;
    logic spd_r;

    // Busy covers the start cycle too, so the caller never double starts
    assign busy = start || low_r || spd_r;

    // Low phase counter and speed-up phase
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_r <= 8'h00;
            low_r <= 1'b0;
            spd_r <= 1'b0;
        end else if (start && !low_r && !spd_r) begin
            cnt_r <= low_len - 8'h01;
            low_r <= 1'b1;
        end else if (low_r) begin
            if (cnt_r == 8'h00) begin
                low_r <= 1'b0;
                spd_r <= 1'b1;
            end else begin
                cnt_r <= cnt_r - 8'h01;
            end
        end else begin
            spd_r <= 1'b0;
        end
    end

    // Pin outputs registered; enable is low while driving
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_o <= 1'b1;
            pin_oe_n <= 1'b1;
        end else if (start && !low_r && !spd_r) begin
            pin_o <= 1'b0;
            pin_oe_n <= 1'b0;
        end else if (low_r && cnt_r == 8'h00) begin
            pin_o <= 1'b1;
            pin_oe_n <= 1'b0;
        end else if (low_r) begin
            pin_o <= 1'b0;
            pin_oe_n <= 1'b0;
        end else begin
            pin_o <= 1'b1;
            pin_oe_n <= 1'b1;
        end
    end

endmodule : dwa_wire_drv

// File: dwa_top.sv
// Acknowledge timing, access timeout and abort handling of the debug wire
`timescale 1ns/1ns
module dwa_top (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic debug_wire_pin_i,
    output logic debug_wire_pin_o,
    output logic debug_wire_pin_oe_n,
    output logic mode_select_input,
    input wire dwa_pkg::dwa_cmd_s cmd,
    input wire dwa_pkg::dwa_core_s core,
    output dwa_pkg::dwa_req_s req
);
    import dwa_pkg::*;

    dwa_state_e state_r;
    logic strap_done_r;
    logic ack_en_r;
    logic dbg_en_r;
    logic no_response_flag_r;
    logic illegal_command_flag_r;
    logic wait_r;
    logic exc_r;
    logic err_r;
    logic with_status_r;
    logic step_r;
    logic core_lp_r;
    logic [7:0] since_end_r;
    logic [9:0] gnt_cnt_r;
    logic acc_hit;
    logic acc_wr;
    logic [31:0] rd_nxt;
    logic drv_start;
    logic [7:0] drv_len;
    logic drv_busy;
    logic meter_en;
    logic resync_req;
    logic high_seen;
    logic set_no_response_flag;
    logic set_illegal_command_flag;
    logic set_wait;
    logic long_start;
    logic step_in_wait;
    logic cmd_take;
    logic min_met;
    logic core_lp;

    // Register address decode, used for read data and for write strobes
    function automatic logic hit(input logic [3:0] addr, input logic [3:0] off);
        hit = (addr == off);
    endfunction : hit

    // Avalon handshake: one wait cycle, then waitrequest drops for one cycle
    assign acc_hit = (avs_read || avs_write) && !avs_waitrequest;
    assign acc_wr = avs_write && !avs_waitrequest;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            avs_waitrequest <= 1'b1;
        end else if (acc_hit) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !(avs_read || avs_write);
        end
    end

    // Read mux; unmapped offsets read as zero
    always_comb begin
        rd_nxt = 32'h0000_0000;
        if (hit(avs_address, DWA_OFF_CTRL)) begin
            rd_nxt[DWA_CTRL_ACK_EN] = ack_en_r;
            rd_nxt[DWA_CTRL_DBG_EN] = dbg_en_r;
        end else if (hit(avs_address, DWA_OFF_STATUS)) begin
            rd_nxt[DWA_ST_NO_RESPONSE_FLAG] = no_response_flag_r;
            rd_nxt[DWA_ST_ILLEGAL_COMMAND_FLAG] = illegal_command_flag_r;
            rd_nxt[DWA_ST_WAIT] = wait_r;
            rd_nxt[DWA_ST_EXC] = exc_r;
            rd_nxt[DWA_ST_PEND] = (state_r != DWA_IDLE);
            rd_nxt[DWA_ST_MODE] = mode_select_input;
        end else if (hit(avs_address, DWA_OFF_INFO)) begin
            rd_nxt[7:0] = since_end_r;
            rd_nxt[17:8] = gnt_cnt_r;
        end
    end

    // Read data is captured when waitrequest is about to drop
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && avs_waitrequest) begin
            avs_readdata <= rd_nxt;
        end
    end

    // Control register
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ack_en_r <= DWA_CTRL_RST[DWA_CTRL_ACK_EN];
            dbg_en_r <= DWA_CTRL_RST[DWA_CTRL_DBG_EN];
        end else if (acc_wr && hit(avs_address, DWA_OFF_CTRL)) begin
            ack_en_r <= avs_writedata[DWA_CTRL_ACK_EN];
            dbg_en_r <= avs_writedata[DWA_CTRL_DBG_EN];
        end
    end

    // Strap caught on the first edge after reset release, not under reset
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            strap_done_r <= 1'b0;
            mode_select_input <= 1'b0;
        end else if (!strap_done_r) begin
            strap_done_r <= 1'b1;
            mode_select_input <= debug_wire_pin_i;
        end
    end

    // Wire logic only runs once the strap is taken
    assign meter_en = strap_done_r && debug_wire_pin_oe_n && !drv_busy;

    dwa_low_meter u_meter (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .enable(meter_en),
        .pin_i(debug_wire_pin_i),
        .resync_req(resync_req),
        .high_seen(high_seen)
    );

    dwa_wire_drv u_drv (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .start(drv_start),
        .low_len(drv_len),
        .busy(drv_busy),
        .pin_o(debug_wire_pin_o),
        .pin_oe_n(debug_wire_pin_oe_n)
    );

    // Command taken only when nothing is outstanding; late ones are dropped
    assign cmd_take = cmd.end_pulse && state_r == DWA_IDLE && strap_done_r && !resync_req;
    assign step_in_wait = cmd.step && core.wait_mode;
    assign core_lp = core.wait_mode || core.stop_mode;

    // Minimum delay from command end depends on acknowledge enable
    assign min_met = ack_en_r ? (since_end_r >= DWA_ACK_MIN_CYC)
                              : (since_end_r >= DWA_NOACK_CYC);

    // Acknowledge pulse start and length
    assign long_start = err_r || exc_r;
    assign drv_start = (state_r == DWA_HOLD && min_met && ack_en_r && !with_status_r)
                       || (state_r == DWA_SYNC_GAP && since_end_r >= DWA_SYNC_GAP_CYC);
    always_comb begin
        drv_len = DWA_ACK_LOW_CYC;
        if (state_r == DWA_SYNC_GAP) begin
            drv_len = DWA_SYNC_RESP_CYC;
        end else if (long_start) begin
            drv_len = DWA_LONG_ACK_CYC;
        end
    end

    // Error and wait events feeding the status flags
    assign set_no_response_flag = (state_r == DWA_ACCESS && !core.gnt && gnt_cnt_r == DWA_GNT_TMO_CYC - 10'h001)
                        || (cmd_take && step_in_wait);
    assign set_illegal_command_flag = cmd_take && step_in_wait;
    assign set_wait = state_r == DWA_ACCESS && core.gnt && step_r && core.wait_mode;

    // Main sequencer
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= DWA_IDLE;
        end else if (resync_req) begin
            state_r <= DWA_SYNC_HIGH;
        end else begin
            case (state_r)
                DWA_IDLE: begin
                    if (cmd_take && step_in_wait) begin
                        state_r <= DWA_HOLD;
                    end else if (cmd_take && cmd.access) begin
                        state_r <= DWA_ACCESS;
                    end else if (cmd_take) begin
                        state_r <= DWA_HOLD;
                    end
                end
                DWA_ACCESS: begin
                    if (core.gnt && step_r && core.wait_mode) begin
                        state_r <= DWA_CORE_WAIT;
                    end else if (core.gnt || set_no_response_flag) begin
                        state_r <= DWA_HOLD;
                    end
                end
                DWA_CORE_WAIT: begin
                    if (!core.wait_mode) begin
                        state_r <= DWA_HOLD;
                    end
                end
                DWA_HOLD: begin
                    if (min_met) begin
                        state_r <= drv_start ? DWA_ACK : DWA_IDLE;
                    end
                end
                DWA_ACK: begin
                    if (!drv_busy) begin
                        state_r <= DWA_IDLE;
                    end
                end
                DWA_SYNC_HIGH: begin
                    if (high_seen) begin
                        state_r <= DWA_SYNC_GAP;
                    end
                end
                DWA_SYNC_GAP: begin
                    if (drv_start) begin
                        state_r <= DWA_SYNC_RESP;
                    end
                end
                DWA_SYNC_RESP: begin
                    if (!drv_busy) begin
                        state_r <= DWA_IDLE;
                    end
                end
                default: begin
                    state_r <= DWA_IDLE;
                end
            endcase
        end
    end

    // Cycles since command end, also reused as the resync gap timer
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            since_end_r <= 8'h00;
        end else if (cmd_take || high_seen) begin
            since_end_r <= 8'h01;
        end else if (since_end_r != 8'hFF) begin
            since_end_r <= since_end_r + 8'h01;
        end
    end

    // Grant timeout counter on the core clock
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            gnt_cnt_r <= 10'h000;
        end else if (state_r == DWA_ACCESS && !resync_req) begin
            gnt_cnt_r <= gnt_cnt_r + 10'h001;
        end else begin
            gnt_cnt_r <= 10'h000;
        end
    end

    // Per-command attributes and error of the command in flight
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            err_r <= 1'b0;
            with_status_r <= 1'b0;
            step_r <= 1'b0;
        end else if (cmd_take) begin
            err_r <= step_in_wait;
            with_status_r <= cmd.with_status;
            step_r <= cmd.step;
        end else if (resync_req) begin
            err_r <= 1'b0;
        end else if (set_no_response_flag) begin
            err_r <= 1'b1;
        end
    end

    // Status flags: hardware set wins over a software clear in the same cycle
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            no_response_flag_r <= 1'b0;
            illegal_command_flag_r <= 1'b0;
            wait_r <= 1'b0;
        end else begin
            if (set_no_response_flag) begin
                no_response_flag_r <= 1'b1;
            end else if (acc_wr && hit(avs_address, DWA_OFF_STATUS) && avs_writedata[DWA_ST_NO_RESPONSE_FLAG]) begin
                no_response_flag_r <= 1'b0;
            end
            if (set_illegal_command_flag) begin
                illegal_command_flag_r <= 1'b1;
            end else if (acc_wr && hit(avs_address, DWA_OFF_STATUS) && avs_writedata[DWA_ST_ILLEGAL_COMMAND_FLAG]) begin
                illegal_command_flag_r <= 1'b0;
            end
            if (set_wait) begin
                wait_r <= 1'b1;
            end else if (acc_wr && hit(avs_address, DWA_OFF_STATUS) && avs_writedata[DWA_ST_WAIT]) begin
                wait_r <= 1'b0;
            end
        end
    end

    // Low-power entry marks the next acknowledge as long
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            core_lp_r <= 1'b0;
            exc_r <= 1'b0;
        end else begin
            core_lp_r <= core_lp;
            if (dbg_en_r && core_lp && !core_lp_r) begin
                exc_r <= 1'b1;
            end else if (state_r == DWA_HOLD && drv_start) begin
                exc_r <= 1'b0;
            end
        end
    end

    // Requests and events toward core and decoder, all registered
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            req <= '0;
        end else begin
            req.access_req <= (state_r == DWA_IDLE && cmd_take && cmd.access && !step_in_wait)
                              || (state_r == DWA_ACCESS && !core.gnt && !set_no_response_flag && !resync_req);
            req.access_abort <= set_no_response_flag && state_r == DWA_ACCESS;
            req.cmd_done <= !resync_req && ((state_r == DWA_HOLD && min_met && !drv_start)
                            || (state_r == DWA_ACK && !drv_busy));
            req.resync <= resync_req;
        end
    end

endmodule : dwa_top

// File: dwa_host_model.sv
// Debug host model: drives abort low pulses on the debug wire
`timescale 1ns/1ns
module dwa_host_model (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic start,
    input wire logic [7:0] low_len,
    output logic pin_o,
    output logic pin_oe_n
);
    logic [7:0] cnt_r;
    // Low for low_len cycles, one driven high cycle, then hand the wire to the pull-up
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_r <= 8'h00;
            pin_o <= 1'b1;
            pin_oe_n <= 1'b1;
        end else if (start) begin
            cnt_r <= low_len;
            pin_o <= 1'b0;
            pin_oe_n <= 1'b0;
        end else if (cnt_r > 8'h01) begin
            cnt_r <= cnt_r - 8'h01;
        end else if (cnt_r == 8'h01) begin
            cnt_r <= 8'h00;
            pin_o <= 1'b1;
        end else begin
            pin_oe_n <= 1'b1;
        end
    end
endmodule : dwa_host_model

// File: dwa_properties.sv
// Checker of acknowledge, abort and bus timing at the block's ports
`timescale 1ns/1ns
module dwa_properties (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic debug_wire_pin_i,
    input wire logic debug_wire_pin_o,
    input wire logic debug_wire_pin_oe_n,
    input wire logic mode_select_input,
    input wire dwa_pkg::dwa_cmd_s cmd,
    input wire dwa_pkg::dwa_core_s core,
    input wire dwa_pkg::dwa_req_s req
);
    import dwa_pkg::*;
    logic busy_r;
    logic [1:0] sc_r;
    logic [7:0] since_r;
    logic [7:0] low_r;
    logic [7:0] wl_r;
    logic [9:0] rq_r;
    wire logic drv_hi = !debug_wire_pin_oe_n && debug_wire_pin_o;
    wire logic ext_low = debug_wire_pin_oe_n && !debug_wire_pin_i;
    // Counters sc_r, since_r and wl_r saturate so a stuck wire cannot wrap them into a false pass; low_r and rq_r wrap
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            busy_r <= 1'b0;
            sc_r <= 2'h0;
            since_r <= 8'h00;
            low_r <= 8'h00;
            wl_r <= 8'h00;
            rq_r <= 10'h000;
        end else begin
            sc_r <= (sc_r == 2'h2) ? sc_r : sc_r + 2'h1;
            busy_r <= (cmd.end_pulse && !busy_r) || (busy_r && !req.cmd_done && !req.resync);
            if (cmd.end_pulse && !busy_r) begin
                since_r <= 8'h01;
            end else begin
                since_r <= (since_r == 8'hFF) ? since_r : since_r + 8'h01;
            end
            low_r <= (!debug_wire_pin_oe_n && !debug_wire_pin_o) ? low_r + 8'h01 : 8'h00;
            wl_r <= !ext_low ? 8'h00 : (wl_r == 8'hFF) ? wl_r : wl_r + 8'h01;
            rq_r <= req.access_req ? rq_r + 10'h001 : 10'h000;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    a_strap_stable: assert property (sc_r == 2'h2 |-> $stable(mode_select_input))
        else $error("mode strap moved after capture");
    a_bus_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=>
        !avs_waitrequest ##1 avs_waitrequest) else $error("bus answer not one wait cycle");
    a_ack_not_early: assert property ($fell(debug_wire_pin_oe_n) && busy_r |-> since_r >= 8'h21)
        else $error("acknowledge started too early");
    a_done_delay: assert property (req.cmd_done && busy_r |-> since_r >= 8'h10)
        else $error("command done too early");
    a_ack_length: assert property (drv_hi && low_r != 8'h00 |-> low_r inside {8'h10, 8'h40, 8'h80})
        else $error("low pulse length wrong");
    a_speedup_one: assert property (drv_hi && low_r != 8'h00 |=> debug_wire_pin_oe_n)
        else $error("speed-up pulse not one cycle");
    a_release_high: assert property ($rose(debug_wire_pin_oe_n) |-> $past(debug_wire_pin_o))
        else $error("wire released from low");
    a_grant_tmo: assert property (req.access_abort |-> rq_r >= 10'h1FF && rq_r <= 10'h201)
        else $error("grant timeout not 512 cycles");
    a_resync_seen: assert property (wl_r == 8'h80 |-> ##[0:2] req.resync)
        else $error("long low not taken as resync");
    a_resync_drop: assert property (req.resync |=> !req.cmd_done [*8])
        else $error("aborted command still completed");
    c_resync: cover property (req.resync);
    c_timeout: cover property (req.access_abort);
    c_long_ack: cover property (drv_hi && low_r == 8'h40);
endmodule : dwa_properties
bind dwa_top dwa_properties u_props (.*);

// File: tb.sv
// Self-checking bench of the debug wire acknowledge and abort block
`timescale 1ns/1ns
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin errors++; \
    $display("CHECK FAILED at %0t: got %h expected %h", $time, (a), (e)); end end
module tb;
    import dwa_pkg::*;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic debug_wire_pin_i;
    logic debug_wire_pin_o;
    logic debug_wire_pin_oe_n;
    logic mode_select_input;
    dwa_cmd_s cmd = '0;
    dwa_core_s core = '0;
    dwa_req_s req;
    logic h_go = 1'b0;
    logic [7:0] h_len = 8'h00;
    logic h_o;
    logic h_oe_n;
    logic [7:0] lowc = 8'h00;
    logic [7:0] ea;
    logic [31:0] er;
    logic [31:0] r;
    logic [31:0] seed = 32'h9172;
    logic [31:0] rd_q[$];
    logic [7:0] ack_q[$];
    int errors = 0;
    int n_tests = 0;
    int i;
    // Pull-up wire: low wins from whichever party drives
    assign debug_wire_pin_i = (debug_wire_pin_oe_n | debug_wire_pin_o) & (h_oe_n | h_o);
    dwa_top dut (.*);
    dwa_host_model host (.ref_clk(ref_clk), .arst_n(arst_n), .start(h_go), .low_len(h_len),
        .pin_o(h_o), .pin_oe_n(h_oe_n));
    initial forever #50 ref_clk = ~ref_clk;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic complete_run();
        if (errors == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : complete_run
    // Scoreboard: an unexpected pulse finds an empty queue and fails
    always @(posedge ref_clk) begin
        if (avs_read && !avs_waitrequest) begin
            er = (rd_q.size() != 0) ? rd_q.pop_front() : 32'hFFFFFFFF;
            `CHK(avs_readdata, er)
        end
        lowc <= (!debug_wire_pin_oe_n && !debug_wire_pin_o) ? lowc + 8'h01 : 8'h00;
        if (!debug_wire_pin_oe_n && debug_wire_pin_o && lowc != 8'h00) begin
            ea = (ack_q.size() != 0) ? ack_q.pop_front() : 8'hFF;
            `CHK(lowc, ea)
        end
    end
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        if (!wr) rd_q.push_back(d);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge ref_clk);
    endtask : bus
    task automatic go(input logic [2:0] q, input logic [7:0] len);
        if (len != 8'h00) ack_q.push_back(len);
        cmd <= {1'b1, q};
        @(posedge ref_clk);
        cmd <= '0;
    endtask : go
    // Second end pulse lands while the first is pending and must be dropped
    task automatic run(input logic [2:0] q, input logic [7:0] len, input logic g);
        go(q, len);
        @(posedge ref_clk);
        go(q, 8'h00);
        if (g) begin
            repeat (2 + rnd() % 8) @(posedge ref_clk);
            core.gnt <= 1'b1;
        end
        for (i = 0; i < 2000 && req.cmd_done !== 1'b1; i++) @(posedge ref_clk);
        `CHK(req.cmd_done, 1'b1)
        core.gnt <= 1'b0;
        @(posedge ref_clk);
    endtask : run
    initial begin
        #6000000;
        errors++;
        complete_run();
    end
    initial begin
        repeat (12) @(posedge ref_clk);
        arst_n <= 1'b1;
        @(posedge ref_clk);
        bus(1'b0, DWA_OFF_CTRL, {30'h0, DWA_CTRL_RST});
        bus(1'b0, DWA_OFF_STATUS, 32'h20);
        `CHK(mode_select_input, 1'b1)
        r = rnd();
        bus(1'b1, 4'hC, r);
        bus(1'b0, 4'hC, 32'h0);
        bus(1'b1, DWA_OFF_CTRL, r);
        bus(1'b0, DWA_OFF_CTRL, r & 32'h3);
        bus(1'b1, DWA_OFF_CTRL, 32'h3);
        run(3'b100, 8'h10, 1'b1);
        run(3'b100, 8'h40, 1'b0);
        bus(1'b0, DWA_OFF_STATUS, 32'h21);
        bus(1'b1, DWA_OFF_STATUS, 32'h7);
        bus(1'b0, DWA_OFF_STATUS, 32'h20);
        run(3'b110, 8'h00, 1'b1);
        bus(1'b1, DWA_OFF_CTRL, 32'h2);
        run(3'b100, 8'h00, 1'b1);
        // Wait entry with debug off, so only the step error makes the long pulse
        bus(1'b1, DWA_OFF_CTRL, 32'h1);
        core.wait_mode <= 1'b1;
        run(3'b101, 8'h40, 1'b0);
        bus(1'b0, DWA_OFF_STATUS, 32'h23);
        bus(1'b1, DWA_OFF_STATUS, 32'h7);
        core.wait_mode <= 1'b0;
        bus(1'b1, DWA_OFF_CTRL, 32'h3);
        core.stop_mode <= 1'b1;
        repeat (2) @(posedge ref_clk);
        core.stop_mode <= 1'b0;
        run(3'b100, 8'h40, 1'b1);
        // Step granted while the core sits in wait: held until wait ends, long ack for the entry
        go(3'b101, 8'h40);
        core.wait_mode <= 1'b1;
        core.gnt <= 1'b1;
        repeat (40) @(posedge ref_clk);
        bus(1'b0, DWA_OFF_STATUS, 32'h3C);
        core.wait_mode <= 1'b0;
        core.gnt <= 1'b0;
        for (i = 0; i < 2000 && req.cmd_done !== 1'b1; i++) @(posedge ref_clk);
        `CHK(req.cmd_done, 1'b1)
        bus(1'b1, DWA_OFF_STATUS, 32'h7);
        // Abort an ungranted access; the device answers with its own long low
        go(3'b100, 8'h80);
        repeat (20) @(posedge ref_clk);
        h_len <= 8'h88;
        h_go <= 1'b1;
        @(posedge ref_clk);
        h_go <= 1'b0;
        for (i = 0; i < 2000 && ack_q.size() != 0; i++) @(posedge ref_clk);
        `CHK(ack_q.size(), 0)
        repeat (4) @(posedge ref_clk);
        `CHK(req.access_req, 1'b0)
        bus(1'b0, DWA_OFF_STATUS, 32'h20);
        run(3'b100, 8'h10, 1'b1);
        repeat (700) @(posedge ref_clk);
        `CHK(ack_q.size() + rd_q.size(), 0)
        complete_run();
    end
endmodule : tb
